// ===== core/chc_pkg.sv
// Package for the heading-control block: command codes, defaults, timing.
// Assumes a 100 MHz system clock and an I2C sensor with pull-ups on both lines.
package chc_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int SCL_HZ = 100_000;
    localparam int SCL_QTR = CLK_HZ / (SCL_HZ * 4);
    // 21 s keeps the cycle count inside a signed int
    localparam int CAL_TIME_S = 21;
    localparam int CAL_CYCLES = CAL_TIME_S * CLK_HZ;
    localparam logic [6:0] SPD_MAX_RST = 7'h3c;
    localparam logic [6:0] SPD_MIN_RST = 7'h0f;
    localparam logic [6:0] SPD_CAL = 7'h14;
    localparam logic [8:0] TOLERANCE = 9'h002;
    localparam logic [8:0] FULL_TURN = 9'h168;
    localparam logic [8:0] SLOW_SPAN = 9'h05a;
    localparam logic [6:0] SENSOR_ADDR_A = 7'h21;
    localparam logic [6:0] SENSOR_ADDR_B = 7'h1e;
    localparam logic [7:0] SENSOR_REG_B = 8'h03;

    typedef enum logic [2:0] {
        CHC_CMD_NONE,
        CHC_CMD_QUERY,
        CHC_CMD_CAL,
        CHC_CMD_OFFSET,
        CHC_CMD_ROTATE,
        CHC_CMD_CEIL,
        CHC_CMD_FLOOR,
        CHC_CMD_SELECT
    } chc_cmd_e;

    typedef struct packed {
        chc_cmd_e code;
        logic [7:0] param;
    } chc_cmd_s;

    typedef struct packed {
        logic run;
        logic dir_cw;
        logic [6:0] speed;
    } chc_motor_s;
endpackage

// ===== core/chc_i2c_reader.sv
// I2C master that fetches one 16-bit big-endian reading from the sensor.
// Assumes open-drain lines with pull-ups; lines are sampled through two flops.
`timescale 1ns/1ps
module chc_i2c_reader (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic kind_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    output logic busy_o,
    output logic done_o,
    output logic nack_o,
    output logic [15:0] data_o
);
    typedef enum logic [2:0] {
        CHC_I_IDLE, CHC_I_START, CHC_I_BIT, CHC_I_STOP, CHC_I_DONE
    } chc_i2c_e;

    chc_i2c_e state_reg;
    logic [1:0] sda_sync_reg;
    logic [1:0] scl_sync_reg;
    logic [15:0] tick_reg;
    logic [1:0] phase_reg;
    logic [5:0] bit_reg;
    logic [44:0] shift_reg;
    logic [44:0] rdmask_reg;
    logic [15:0] data_reg;
    logic sda_drv_reg;
    logic scl_low_reg;
    logic nack_reg;
    logic done_reg;

    wire logic tick = (tick_reg == 16'(chc_pkg::SCL_QTR - 1));
    wire logic sda_in = sda_sync_reg[1];
    // Address with read bit, then two bytes read, ACK after the first, NACK after the last
    wire logic [6:0] addr = kind_i ? chc_pkg::SENSOR_ADDR_B : chc_pkg::SENSOR_ADDR_A;
    wire logic [44:0] frame = {addr, 1'b1, 1'b1, 8'hff, 1'b0, 8'hff, 1'b1, 18'h3ffff};
    wire logic [44:0] mask = {8'h00, 1'b1, 8'hff, 1'b0, 8'hff, 1'b0, 18'h00000};

    assign scl_o = 1'b0;
    assign scl_oe_o = scl_low_reg;
    assign sda_o = 1'b0;
    assign sda_oe_o = ~sda_drv_reg;
    assign busy_o = (state_reg != CHC_I_IDLE);
    assign done_o = done_reg;
    assign nack_o = nack_reg;
    assign data_o = data_reg;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sda_sync_reg <= 2'h3;
            scl_sync_reg <= 2'h3;
        end
        else
        begin
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            tick_reg <= 16'h0000;
        else if (tick || state_reg == CHC_I_IDLE)
            tick_reg <= 16'h0000;
        else
            tick_reg <= tick_reg + 16'h0001;
    end

    // Bits pass MSB first; phase 0 sets data, 1-2 clock high, 3 clock low
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg <= CHC_I_IDLE;
            phase_reg <= 2'h0;
            bit_reg <= 6'h00;
            shift_reg <= '0;
            rdmask_reg <= '0;
            data_reg <= 16'h0000;
            sda_drv_reg <= 1'b1;
            scl_low_reg <= 1'b0;
            nack_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            case (state_reg)
                CHC_I_IDLE:
                    if (start_i)
                    begin
                        state_reg <= CHC_I_START;
                        shift_reg <= frame;
                        rdmask_reg <= mask;
                        bit_reg <= 6'd27;
                        nack_reg <= 1'b0;
                    end
                CHC_I_START:
                    if (tick)
                    begin
                        phase_reg <= phase_reg + 2'h1;
                        if (phase_reg == 2'h0)
                            sda_drv_reg <= 1'b0;
                        else if (phase_reg == 2'h1)
                            scl_low_reg <= 1'b1;
                        else if (phase_reg == 2'h3)
                            state_reg <= CHC_I_BIT;
                    end
                CHC_I_BIT:
                    if (tick)
                    begin
                        phase_reg <= phase_reg + 2'h1;
                        if (phase_reg == 2'h0)
                            sda_drv_reg <= shift_reg[44];
                        else if (phase_reg == 2'h1)
                            scl_low_reg <= 1'b0;
                        else if (phase_reg == 2'h2)
                        begin
                            if (rdmask_reg[44])
                                data_reg <= {data_reg[14:0], sda_in};
                            // Only the address acknowledge slot is checked for a NACK from the sensor
                            if (bit_reg == 6'd19)
                                nack_reg <= nack_reg | sda_in;
                        end
                        else
                        begin
                            scl_low_reg <= 1'b1;
                            shift_reg <= {shift_reg[43:0], 1'b1};
                            rdmask_reg <= {rdmask_reg[43:0], 1'b0};
                            bit_reg <= bit_reg - 6'h01;
                            if (bit_reg == 6'h01)
                                state_reg <= CHC_I_STOP;
                        end
                    end
                CHC_I_STOP:
                    if (tick)
                    begin
                        phase_reg <= phase_reg + 2'h1;
                        if (phase_reg == 2'h0)
                            sda_drv_reg <= 1'b0;
                        else if (phase_reg == 2'h1)
                            scl_low_reg <= 1'b0;
                        else if (phase_reg == 2'h2)
                            sda_drv_reg <= 1'b1;
                        else
                        begin
                            state_reg <= CHC_I_DONE;
                        end
                    end
                default:
                begin
                    done_reg <= 1'b1;
                    state_reg <= CHC_I_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== core/chc_heading_ctrl.sv
// Heading control: sensor polling, offset, calibration turn, rotate-to-heading.
// Assumes commands arrive as one-cycle strobes from host logic on clk_i.
`timescale 1ns/1ps
module chc_heading_ctrl #(
    parameter int CAL_CYCLES = chc_pkg::CAL_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire chc_pkg::chc_cmd_s cmd_i,
    input wire logic cmd_valid_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    output chc_pkg::chc_motor_s motor_o,
    output logic reply_o,
    output logic [8:0] reply_data_o,
    output logic busy_o,
    output logic sensor_err_o
);
    typedef enum logic [1:0] {CHC_IDLE, CHC_CAL, CHC_ROT} chc_mode_e;

    chc_mode_e mode_reg;
    logic fitted_reg;
    logic kind_reg;
    logic [7:0] offset_reg;
    logic [7:0] target_reg;
    logic [6:0] ceil_reg;
    logic [6:0] floor_reg;
    logic [8:0] heading_reg;
    logic [31:0] cal_reg;
    logic reply_reg;
    logic [8:0] reply_data_reg;
    logic poll_reg;
    chc_pkg::chc_motor_s motor_reg;
    logic rd_done;
    logic rd_nack;
    logic rd_busy;
    logic [15:0] rd_data;

    ////////////////////////////////////////////////////////////////////////
    // Sensor reads tenths of a degree; the divide is fine at this poll rate
    wire logic [15:0] raw_deg = rd_data / 16'd10;
    wire logic [9:0] raw_mod = (raw_deg >= 16'd360) ? 10'd0 : raw_deg[9:0];
    wire logic [9:0] sum_deg = raw_mod + {1'b0, offset_reg, 1'b0};
    wire logic [8:0] cur_deg = (sum_deg >= 10'd360) ? 9'(sum_deg - 10'd360) : sum_deg[8:0];
    wire logic [8:0] tgt_raw = {target_reg, 1'b0};
    wire logic [8:0] tgt_deg = (tgt_raw >= chc_pkg::FULL_TURN) ? 9'(tgt_raw - chc_pkg::FULL_TURN)
                                                               : tgt_raw;
    // Shortest way round, modulo 360
    wire logic [9:0] fwd = (tgt_deg >= heading_reg) ? 10'(tgt_deg - heading_reg)
                                                    : 10'(tgt_deg + 10'd360 - heading_reg);
    wire logic go_cw = (fwd <= 10'd180);
    wire logic [8:0] gap = go_cw ? fwd[8:0] : 9'(10'd360 - fwd);
    wire logic at_target = (gap <= chc_pkg::TOLERANCE);
    // Linear ramp over the last quarter turn, clamped to the floor
    wire logic [6:0] span = (ceil_reg > floor_reg) ? 7'(ceil_reg - floor_reg) : 7'h00;
    // Product needs 14 bits; a self-sized 9-bit multiply would wrap
    wire logic [15:0] ramp_prod = 16'(span) * 16'(gap);
    wire logic [15:0] ramp = (gap >= chc_pkg::SLOW_SPAN) ? {9'h000, span}
                             : ramp_prod / 16'(chc_pkg::SLOW_SPAN);
    wire logic [6:0] rot_speed = 7'(floor_reg + ramp[6:0]);
    wire logic cmd_go = cmd_valid_i && (mode_reg == CHC_IDLE);

    assign busy_o = (mode_reg != CHC_IDLE);
    assign reply_o = reply_reg;
    assign reply_data_o = reply_data_reg;
    assign motor_o = motor_reg;
    assign sensor_err_o = rd_nack;

    chc_i2c_reader u_reader (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(poll_reg),
        .kind_i(kind_reg),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_o(scl_o),
        .scl_oe_o(scl_oe_o),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .busy_o(rd_busy),
        .done_o(rd_done),
        .nack_o(rd_nack),
        .data_o(rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Polls only when a sensor is fitted, so an empty bus never stalls us
    // Heading moves only on a clean read; a refused frame keeps the last value
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            poll_reg <= 1'b0;
            heading_reg <= 9'h000;
        end
        else
        begin
            poll_reg <= fitted_reg && !rd_busy && !poll_reg;
            if (rd_done && !rd_nack)
                heading_reg <= cur_deg;
        end
    end

    // Configuration; only taken while idle so a move keeps its limits
    // Clamps keep speeds within 0..100 and the offset below a full turn
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fitted_reg <= 1'b0;
            kind_reg <= 1'b0;
            offset_reg <= 8'h00;
            target_reg <= 8'h00;
            ceil_reg <= chc_pkg::SPD_MAX_RST;
            floor_reg <= chc_pkg::SPD_MIN_RST;
        end
        else if (cmd_go)
        begin
            case (cmd_i.code)
                chc_pkg::CHC_CMD_SELECT:
                begin
                    fitted_reg <= cmd_i.param[1];
                    kind_reg <= cmd_i.param[0];
                end
                chc_pkg::CHC_CMD_OFFSET: offset_reg <= (cmd_i.param > 8'd179) ? 8'd179
                                                                               : cmd_i.param;
                chc_pkg::CHC_CMD_ROTATE: target_reg <= cmd_i.param;
                chc_pkg::CHC_CMD_CEIL: ceil_reg <= (cmd_i.param > 8'd100) ? 7'd100
                                                                          : cmd_i.param[6:0];
                chc_pkg::CHC_CMD_FLOOR: floor_reg <= (cmd_i.param > 8'd100) ? 7'd100
                                                                            : cmd_i.param[6:0];
                default: ;
            endcase
        end
    end

    // Mode machine; replies are one-cycle pulses
    // Commands met while busy are dropped with no reply; the host waits for one
    // Limitation: a sensor that stops answering leaves a rotation running
    // until the host resets the block
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode_reg <= CHC_IDLE;
            cal_reg <= 32'h0000_0000;
            reply_reg <= 1'b0;
            reply_data_reg <= 9'h000;
            motor_reg <= '0;
        end
        else
        begin
            reply_reg <= 1'b0;
            case (mode_reg)
                CHC_IDLE:
                begin
                    motor_reg <= '0;
                    if (cmd_go)
                    begin
                        if (cmd_i.code == chc_pkg::CHC_CMD_CAL)
                        begin
                            mode_reg <= CHC_CAL;
                            cal_reg <= 32'h0000_0000;
                        end
                        else if (cmd_i.code == chc_pkg::CHC_CMD_ROTATE && fitted_reg)
                            mode_reg <= CHC_ROT;
                        else if (cmd_i.code != chc_pkg::CHC_CMD_NONE)
                        begin
                            reply_reg <= 1'b1;
                            reply_data_reg <= heading_reg;
                        end
                    end
                end
                CHC_CAL:
                begin
                    motor_reg <= '{run: 1'b1, dir_cw: 1'b1, speed: chc_pkg::SPD_CAL};
                    cal_reg <= cal_reg + 32'h0000_0001;
                    if (cal_reg == 32'(CAL_CYCLES - 1))
                    begin
                        mode_reg <= CHC_IDLE;
                        motor_reg <= '0;
                        reply_reg <= 1'b1;
                        reply_data_reg <= heading_reg;
                    end
                end
                default:
                begin
                    motor_reg <= '{run: 1'b1, dir_cw: go_cw, speed: rot_speed};
                    if (at_target)
                    begin
                        mode_reg <= CHC_IDLE;
                        motor_reg <= '0;
                        reply_reg <= 1'b1;
                        reply_data_reg <= heading_reg;
                    end
                end
            endcase
        end
    end
endmodule

// ===== verification/chc_heading_ctrl_properties.sv
// Concurrent checks on the heading-control block's ports.
// Assumes one clock domain; CAL_CYCLES is handed on by the bind.
`timescale 1ns/1ps
module chc_heading_ctrl_properties #(
    parameter int CAL_CYCLES = 200
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire chc_pkg::chc_cmd_s cmd_i,
    input wire logic cmd_valid_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire chc_pkg::chc_motor_s motor_o,
    input wire logic reply_o,
    input wire logic [8:0] reply_data_o,
    input wire logic busy_o,
    input wire logic sensor_err_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire logic taken = cmd_valid_i && !busy_o;
    ////////////////////////////////////////////////////////////
    sequence cal_turn_s;
        busy_o ##1 (motor_o.run && motor_o.dir_cw && motor_o.speed == chc_pkg::SPD_CAL);
    endsequence
    query_reply_a: assert property (taken && cmd_i.code == chc_pkg::CHC_CMD_QUERY |=> reply_o)
        else $error("query got no reply");
    none_silent_a: assert property (taken && cmd_i.code == chc_pkg::CHC_CMD_NONE |=> !reply_o)
        else $error("empty command replied");
    cal_start_a: assert property (taken && cmd_i.code == chc_pkg::CHC_CMD_CAL |=> cal_turn_s)
        else $error("calibration turn not started");
    reply_pulse_a: assert property (reply_o && !taken |=> !reply_o)
        else $error("reply longer than one cycle");
    data_hold_a: assert property (!reply_o |-> $stable(reply_data_o))
        else $error("reply data moved without reply");
    heading_range_a: assert property (reply_o |-> reply_data_o < chc_pkg::FULL_TURN)
        else $error("heading outside one turn");
    speed_limit_a: assert property (motor_o.run |-> motor_o.speed <= 7'h64)
        else $error("speed above 100");
    open_drain_a: assert property (!scl_o && !sda_o)
        else $error("bus line driven high");
    idle_still_a: assert property (!busy_o ##1 !busy_o |-> !motor_o.run)
        else $error("motor runs while idle");
    done_reply_a: assert property ($fell(busy_o) |-> ##[0:1] (reply_o || $past(reply_o)))
        else $error("motion ended without reply");
    reset_clean_a: assert property ($fell(rst_i) |-> !busy_o && !motor_o.run && !sda_oe_o)
        else $error("not quiet after reset");
endmodule
bind chc_heading_ctrl chc_heading_ctrl_properties #(.CAL_CYCLES(CAL_CYCLES)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i),
    .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .motor_o(motor_o), .reply_o(reply_o),
    .reply_data_o(reply_data_o), .busy_o(busy_o), .sensor_err_o(sensor_err_o)
);

// ===== verification/chc_sensor_model.sv
// Behavioural heading sensor: answers one 16-bit reading per bus frame sent to its address.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps
module chc_sensor_model #(
    parameter logic [6:0] ADDR = 7'h21
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [15:0] raw_i,
    output logic sda_oe_o,
    output int n_reads_o
);
    int bitn = 0;
    int byten = 5;
    logic [7:0] sh = 8'h00;
    logic sel = 1'b0;
    initial
    begin
        sda_oe_o = 1'b0;
        n_reads_o = 0;
    end
    ////////////////////////////////////////////////////////////
    always @(negedge sda_i)
    begin
        if (scl_i)
        begin
            bitn = -1;
            byten = 0;
            sel = 1'b0;
        end
    end
    always @(posedge sda_i)
    begin
        if (scl_i && byten == 3 && sel)
        begin
            n_reads_o++;
            byten = 5;
        end
    end
    always @(posedge scl_i)
    begin
        if (bitn < 8)
            sh = {sh[6:0], sda_i};
    end
    // Changes only after scl falls, so no false start or stop is seen
    always @(negedge scl_i)
    begin
        bitn = bitn + 1;
        if (bitn == 9)
        begin
            bitn = 0;
            byten = byten + 1;
        end
        if (bitn == 8 && byten == 0)
            sel = (sh[7:1] == ADDR);
        if (bitn == 8)
            sda_oe_o = (byten == 0) && sel;
        else if (byten == 1 || byten == 2)
            sda_oe_o = sel && !raw_i[(2 - byten) * 8 + 7 - bitn];
        else
            sda_oe_o = 1'b0;
    end
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the heading-control block with a sensor model.
// Assumes pull-ups on both bus lines, modelled as wired-AND.
`timescale 1ns/1ps
module tb_top;
    localparam int CALC = 200;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    chc_pkg::chc_cmd_s cmd_i = '0;
    logic cmd_valid_i = 1'b0;
    logic scl_o, scl_oe_o, sda_o, sda_oe_o, reply_o, busy_o, sensor_err_o, m_sda_oe;
    logic [8:0] reply_data_o;
    chc_pkg::chc_motor_s motor_o;
    logic [15:0] raw = 16'h0000;
    logic [9:0] exp_q[$];
    logic [9:0] mon_e;
    logic [31:0] rnd = 32'h00407a8f;
    int n_errors = 0;
    int checked = 0;
    int n_rep = 0;
    int n_reads;
    wire logic scl_w = !scl_oe_o;
    wire logic sda_w = !(sda_oe_o || m_sda_oe);
    always #5 clk_i = ~clk_i;
    chc_heading_ctrl #(.CAL_CYCLES(CALC)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i),
        .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .motor_o(motor_o), .reply_o(reply_o),
        .reply_data_o(reply_data_o), .busy_o(busy_o), .sensor_err_o(sensor_err_o)
    );
    chc_sensor_model #(.ADDR(chc_pkg::SENSOR_ADDR_A)) u_sensor (
        .scl_i(scl_w), .sda_i(sda_w), .raw_i(raw), .sda_oe_o(m_sda_oe), .n_reads_o(n_reads)
    );
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [9:0] seen, input logic [9:0] want);
        checked++;
        if (seen !== want)
        begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // Bit 9 of a note marks reply data that need not be compared
    task automatic send(input chc_pkg::chc_cmd_e c, input logic [7:0] p, input logic [9:0] e);
        @(posedge clk_i);
        #1;
        cmd_i = '{c, p};
        cmd_valid_i = 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        #1;
        cmd_valid_i = 1'b0;
    endtask
    task automatic wait_q(input int lim);
        for (int i = 0; i < lim && exp_q.size() > 0; i++)
            @(posedge clk_i);
        check(10'(exp_q.size()), 10'h000);
    endtask
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        if (reply_o === 1'b1)
        begin
            n_rep++;
            if (exp_q.size() == 0)
                check(10'h3ff, 10'h000);
            else
            begin
                mon_e = exp_q.pop_front();
                if (!mon_e[9])
                    check({1'b0, reply_data_o}, mon_e);
            end
        end
    end
    initial
    begin
        repeat (90000) @(posedge clk_i);
        n_errors++;
        give_verdict();
    end
    initial
    begin
        int h;
        int off;
        int base;
        repeat (2) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        send(chc_pkg::CHC_CMD_QUERY, 8'h00, 10'h000);
        send(chc_pkg::CHC_CMD_CEIL, 8'h3c, 10'h000);
        send(chc_pkg::CHC_CMD_FLOOR, 8'h0f, 10'h000);
        wait_q(10);
        send(chc_pkg::CHC_CMD_NONE, 8'h00, 10'h000);
        repeat (3) @(posedge clk_i);
        check(10'(exp_q.size()), 10'h001);
        exp_q.delete();
        $display("Idle commands done");
        base = n_rep;
        send(chc_pkg::CHC_CMD_CAL, 8'h00, 10'h000);
        repeat (CALC - 20) @(posedge clk_i);
        check(10'(n_rep - base), 10'h000);
        wait_q(400);
        send(chc_pkg::CHC_CMD_ROTATE, 8'h2d, 10'h000);
        wait_q(10);
        check({9'h000, motor_o.run}, 10'h000);
        $display("Calibration and unfitted rotate done");
        rnd = lfsr(rnd);
        off = int'(rnd[15:0]) % 180;
        rnd = lfsr(rnd);
        raw = 16'(int'(rnd[15:0]) % 3600);
        h = (raw / 10 + 2 * off) % 360;
        send(chc_pkg::CHC_CMD_OFFSET, 8'(off), 10'h200);
        send(chc_pkg::CHC_CMD_SELECT, 8'h03, 10'h200);
        wait_q(10);
        for (int i = 0; i < 32000 && sensor_err_o !== 1'b1; i++)
            @(posedge clk_i);
        check(10'(sensor_err_o), 10'h001);
        send(chc_pkg::CHC_CMD_SELECT, 8'h02, 10'h200);
        wait_q(10);
        for (int i = 0; i < 60000 && n_reads < 1; i++)
            @(posedge clk_i);
        repeat (300) @(posedge clk_i);
        check(10'(n_reads > 0), 10'h001);
        check(10'(sensor_err_o), 10'h000);
        send(chc_pkg::CHC_CMD_QUERY, 8'h00, 10'(h));
        wait_q(10);
        send(chc_pkg::CHC_CMD_ROTATE, 8'(h / 2), 10'(h));
        wait_q(50000);
        $display("Offset reading and near rotate done");
        send(chc_pkg::CHC_CMD_ROTATE, 8'(((h + 120) % 360) / 2), 10'h200);
        for (int i = 0; i < 50000 && motor_o.run !== 1'b1; i++)
            @(posedge clk_i);
        #1;
        check(10'({motor_o.run, motor_o.dir_cw, motor_o.speed}), {3'h3, chc_pkg::SPD_MAX_RST});
        rst_i = 1'b1;
        exp_q.delete();
        repeat (2) @(posedge clk_i);
        #1;
        check(10'({busy_o, motor_o}), 10'h000);
        rst_i = 1'b0;
        $display("Far rotate and mid-run reset done");
        give_verdict();
    end
endmodule
